// >>> rtl/ssp_defs.vh
// Constants for one synchronous serial port channel.
// Assumes a single system clock; included by the channel module.
// Notes on behaviour
// - Completed word moves to receive holding, sets full.
// - Receive-full request when full and enabled.
// - DMA read of receive holding clears full.
// - Receive holding resets to zero.
// - Transmit shifts MSB first on bit clock rise.
// - Eight-bit mode sends only low byte.
// - Sync or word end loads shifter, sets empty.
// - Start while still empty flags underrun, error request.
// - Write while not empty silently replaces pending word.
// - Transmit-empty request when empty and enabled.
// - DMA write clears empty; only hardware sets it.
// - Control is 16 bits, resets zero, high bits zero.
// - Bit 6 picks external or internal transmit sync.
// - Bit 5 needs sync every word or first only.
// - Bit 4 picks eight or sixteen bit words.
// - Bits 3 and 2 enable transmit-empty and receive-full requests.
// - Transmit disabled releases transmit pins.
// - Receive disabled ignores receive pins.
// - Receive samples MSB first on bit clock fall.
// - Word completing while full sets overrun, overwrites.
// - Flags clear by reading one, writing zero.
// - Clearing receive enable clears full.
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define SSP_OFF_RXDATA 4'h0
`define SSP_OFF_TXDATA 4'h2
`define SSP_OFF_CTRL 4'h4
`define SSP_OFF_FLAGS 4'h6
`define SSP_CTRL_RESET 16'h0000
`define SSP_FLAGS_RESET 4'h2
`define SSP_DATA_RESET 16'h0000
`define SSP_CTRL_MASK 16'h007F
`define SSP_B_RX_EN 0
`define SSP_B_TX_EN 1
`define SSP_B_RX_IE 2
`define SSP_B_TX_IE 3
`define SSP_B_WLEN 4
`define SSP_B_SE 5
`define SSP_B_TM 6
`define SSP_F_RXFULL 0
`define SSP_F_TXEMPTY 1
`define SSP_F_RXOVR 2
`define SSP_F_TXUND 3
`define SSP_BITS_8 5'h08
`define SSP_BITS_16 5'h10
`endif

// >>> rtl/ssp_channel.v
// One channel of a full-duplex synchronous serial port.
// Assumes pin clocks are much slower than clk and that the register
// port and DMA strobes are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defs.vh"
module ssp_channel
(
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  input wire dma_rd,
  input wire dma_wr,
  input wire rx_serial_in,
  input wire rx_bit_clock,
  input wire rx_frame_sync,
  input wire tx_bit_clock,
  output reg tx_serial_out_q,
  output wire tx_serial_out_oe,
  input wire tx_frame_sync_in,
  output reg tx_frame_sync_out_q,
  output wire tx_frame_sync_oe,
  output wire rx_full_irq,
  output wire tx_empty_irq,
  output wire rx_overrun_irq,
  output wire tx_underrun_irq
);

  reg [15:0] ctrl_q;
  reg [15:0] rx_hold_q;
  reg [15:0] tx_hold_q;
  reg [15:0] rx_shift_q;
  reg [15:0] tx_shift_q;
  reg [3:0] flags_q;
  reg [3:0] armed_q;
  reg [4:0] rx_cnt_q;
  reg [4:0] tx_cnt_q;
  reg rx_run_q;
  reg tx_run_q;
  reg [2:0] rxc_s;
  reg [2:0] txc_s;
  reg [1:0] rxd_s;
  reg [1:0] rxf_s;
  reg [1:0] txf_s;
  reg [15:0] reg_rdata_d;

  wire rx_en = ctrl_q[`SSP_B_RX_EN];
  wire tx_en = ctrl_q[`SSP_B_TX_EN];
  wire every_word = ctrl_q[`SSP_B_SE];
  wire internal_sync = ctrl_q[`SSP_B_TM];
  wire [4:0] word_bits = ctrl_q[`SSP_B_WLEN] ? `SSP_BITS_16 : `SSP_BITS_8;

  // Edge finders on the synchronised pin clocks.
  function edge_rise;
    input [2:0] taps;
    begin
      edge_rise = taps[1] & ~taps[2];
    end
  endfunction

  function edge_fall;
    input [2:0] taps;
    begin
      edge_fall = taps[2] & ~taps[1];
    end
  endfunction

  // Register select shared by every strobe decode.
  function addr_is;
    input [3:0] addr;
    input [3:0] offset;
    begin
      addr_is = addr == offset;
    end
  endfunction

  // Edges are found on the second and third stages only.
  wire rx_fall = edge_fall(rxc_s) & rx_en;
  wire tx_rise = edge_rise(txc_s) & tx_en;

  wire wr_hit_tx = reg_wr & addr_is(reg_addr, `SSP_OFF_TXDATA);
  wire wr_hit_ctrl = reg_wr & addr_is(reg_addr, `SSP_OFF_CTRL);
  wire wr_hit_flags = reg_wr & addr_is(reg_addr, `SSP_OFF_FLAGS);
  wire rd_hit_flags = reg_rd & addr_is(reg_addr, `SSP_OFF_FLAGS);

  // Receive word boundary and start decisions.
  wire rx_last = rx_cnt_q == word_bits - 5'h01;
  wire rx_start = ~rx_run_q & rxf_s[1];
  wire rx_take = rx_fall & (rx_run_q | rx_start);
  wire rx_done = rx_take & (rx_start ? (word_bits == 5'h01) : rx_last);
  wire [15:0] rx_word = {rx_shift_q[14:0], rxd_s[1]};
  // Short words would carry stale bits above the byte, so they are cleared.
  wire [15:0] rx_fit = ctrl_q[`SSP_B_WLEN] ? rx_word :
                       {8'h00, rx_word[7:0]};

  // Transmit start: external sync level, internal sync, or chained word.
  wire tx_last = tx_run_q & (tx_cnt_q == word_bits - 5'h01);
  wire tx_chain = tx_last & ~every_word;
  wire tx_ext_go = ~internal_sync & txf_s[1];
  wire tx_int_go = internal_sync & ~flags_q[`SSP_F_TXEMPTY];
  wire tx_idle_ok = ~tx_run_q | tx_last;
  wire tx_start = tx_rise & (tx_chain | (tx_idle_ok & (tx_ext_go | tx_int_go)));
  // Short words are left-aligned so the MSB path is shared.
  wire [15:0] tx_load = ctrl_q[`SSP_B_WLEN] ? tx_hold_q :
                        {tx_hold_q[7:0], 8'h00};

  // Clear on software write of zero only after the bit was read as one.
  function clr_ok;
    input [3:0] armed;
    input [3:0] wdat;
    input integer idx;
    begin
      clr_ok = armed[idx] & ~wdat[idx];
    end
  endfunction

  wire sw_clr_full = wr_hit_flags & clr_ok(armed_q, reg_wdata[3:0],
                     `SSP_F_RXFULL);
  wire sw_clr_empty = wr_hit_flags & clr_ok(armed_q, reg_wdata[3:0],
                      `SSP_F_TXEMPTY);
  wire sw_clr_ovr = wr_hit_flags & clr_ok(armed_q, reg_wdata[3:0],
                    `SSP_F_RXOVR);
  wire sw_clr_und = wr_hit_flags & clr_ok(armed_q, reg_wdata[3:0],
                    `SSP_F_TXUND);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxc_s <= 3'h0;
      txc_s <= 3'h0;
      rxd_s <= 2'h0;
      rxf_s <= 2'h0;
      txf_s <= 2'h0;
    end
    else
    begin
      rxc_s <= {rxc_s[1:0], rx_bit_clock};
      txc_s <= {txc_s[1:0], tx_bit_clock};
      rxd_s <= {rxd_s[0], rx_serial_in};
      rxf_s <= {rxf_s[0], rx_frame_sync};
      txf_s <= {txf_s[0], tx_frame_sync_in};
    end
  end

  // Read data for the next cycle; a DMA read wins over the CPU.
  always @*
  begin
    reg_rdata_d = reg_rdata_q;
    if (dma_rd)
      reg_rdata_d = rx_hold_q;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SSP_OFF_RXDATA: reg_rdata_d = rx_hold_q;
        `SSP_OFF_TXDATA: reg_rdata_d = tx_hold_q;
        `SSP_OFF_CTRL: reg_rdata_d = ctrl_q;
        `SSP_OFF_FLAGS: reg_rdata_d = {12'h000, flags_q};
        default: reg_rdata_d = 16'h0000;
      endcase
    end
  end

  // Register file.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `SSP_CTRL_RESET;
      tx_hold_q <= `SSP_DATA_RESET;
      rx_hold_q <= `SSP_DATA_RESET;
      reg_rdata_q <= `SSP_DATA_RESET;
    end
    else
    begin
      if (wr_hit_ctrl)
        ctrl_q <= reg_wdata & `SSP_CTRL_MASK;
      // A write while a word is pending overwrites it without error.
      if (wr_hit_tx | dma_wr)
        tx_hold_q <= reg_wdata;
      if (rx_done)
        rx_hold_q <= rx_fit;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Status flags; a flag read arms the clear of the bits read as one.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q <= `SSP_FLAGS_RESET;
      armed_q <= 4'h0;
    end
    else
    begin
      if (rd_hit_flags)
        armed_q <= flags_q;
      else if (wr_hit_flags)
        armed_q <= 4'h0;
      // Set has priority over every clear below.
      if (rx_done)
        flags_q[`SSP_F_RXFULL] <= 1'b1;
      else if (dma_rd | sw_clr_full | ~rx_en)
        flags_q[`SSP_F_RXFULL] <= 1'b0;
      if (rx_done & flags_q[`SSP_F_RXFULL])
        flags_q[`SSP_F_RXOVR] <= 1'b1;
      else if (sw_clr_ovr)
        flags_q[`SSP_F_RXOVR] <= 1'b0;
      if (tx_start | ~tx_en)
        flags_q[`SSP_F_TXEMPTY] <= 1'b1;
      else if (dma_wr | sw_clr_empty)
        flags_q[`SSP_F_TXEMPTY] <= 1'b0;
      if (tx_start & flags_q[`SSP_F_TXEMPTY])
        flags_q[`SSP_F_TXUND] <= 1'b1;
      else if (sw_clr_und)
        flags_q[`SSP_F_TXUND] <= 1'b0;
    end
  end

  // Receive shifter.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_shift_q <= 16'h0000;
      rx_cnt_q <= 5'h00;
      rx_run_q <= 1'b0;
    end
    else if (~rx_en)
    begin
      rx_cnt_q <= 5'h00;
      rx_run_q <= 1'b0;
    end
    else if (rx_take)
    begin
      rx_shift_q <= rx_word;
      if (rx_done)
      begin
        rx_cnt_q <= 5'h00;
        rx_run_q <= ~every_word;
      end
      else
      begin
        rx_cnt_q <= rx_start ? 5'h01 : rx_cnt_q + 5'h01;
        rx_run_q <= 1'b1;
      end
    end
  end

  // Transmit shifter; the output bit changes only on a bit clock rise.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_shift_q <= 16'h0000;
      tx_cnt_q <= 5'h00;
      tx_run_q <= 1'b0;
      tx_serial_out_q <= 1'b0;
      tx_frame_sync_out_q <= 1'b0;
    end
    else if (~tx_en)
    begin
      tx_cnt_q <= 5'h00;
      tx_run_q <= 1'b0;
      tx_frame_sync_out_q <= 1'b0;
    end
    else if (tx_rise)
    begin
      if (tx_start)
      begin
        tx_shift_q <= {tx_load[14:0], 1'b0};
        tx_serial_out_q <= tx_load[15];
        tx_cnt_q <= 5'h00;
        tx_run_q <= 1'b1;
        tx_frame_sync_out_q <= internal_sync & ~tx_chain;
      end
      else if (tx_last)
      begin
        tx_run_q <= 1'b0;
        tx_frame_sync_out_q <= 1'b0;
      end
      else if (tx_run_q)
      begin
        tx_shift_q <= {tx_shift_q[14:0], 1'b0};
        tx_serial_out_q <= tx_shift_q[15];
        tx_cnt_q <= tx_cnt_q + 5'h01;
        tx_frame_sync_out_q <= 1'b0;
      end
    end
  end

  assign tx_serial_out_oe = tx_en;
  assign tx_frame_sync_oe = tx_en & internal_sync;
  assign rx_full_irq = ctrl_q[`SSP_B_RX_IE] & flags_q[`SSP_F_RXFULL];
  assign tx_empty_irq = ctrl_q[`SSP_B_TX_IE] &
                        flags_q[`SSP_F_TXEMPTY];
  assign rx_overrun_irq = flags_q[`SSP_F_RXOVR];
  assign tx_underrun_irq = flags_q[`SSP_F_TXUND];

endmodule
`default_nettype wire

// >>> test/ssp_channel_properties.sv
// Checker on the pins of one serial port channel.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module ssp_channel_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic dma_rd,
  input wire logic dma_wr,
  input wire logic tx_serial_out_oe,
  input wire logic tx_frame_sync_oe,
  input wire logic rx_full_irq,
  input wire logic tx_empty_irq,
  input wire logic tx_underrun_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire cw = reg_wr && reg_addr == 4'h4;
  a_tx_pins:
  assert property (cw |=> tx_serial_out_oe == $past(reg_wdata[1]))
    else $error("transmit enable wrong");
  a_sync_drive:
  assert property (cw |=> tx_frame_sync_oe == $past(reg_wdata[1] & reg_wdata[6]))
    else $error("sync drive wrong");
  a_txirq_mask:
  assert property (cw && !reg_wdata[3] |=> !tx_empty_irq)
    else $error("empty request unmasked");
  a_rxirq_mask:
  assert property (cw && !reg_wdata[2] |=> !rx_full_irq)
    else $error("full request unmasked");
  a_dma_rdclr:
  assert property (dma_rd |=> !rx_full_irq)
    else $error("full kept after dma read");
  a_dma_wrclr:
  assert property (dma_wr && tx_serial_out_oe |=> !tx_empty_irq)
    else $error("empty kept after dma write");
  a_ctrl_high:
  assert property (reg_rd && reg_addr == 4'h4 && !dma_rd |=>
    reg_rdata_q[15:7] == 9'h000)
    else $error("control high bits set");
  a_und_keep:
  assert property (tx_underrun_irq && !(reg_wr && reg_addr == 4'h6) |=>
    tx_underrun_irq)
    else $error("underrun lost");
endmodule
`default_nettype wire

// >>> test/ssp_codec.sv
// Codec model on the serial pins of one channel.
// Assumes the bench calls frame one at a time.
`timescale 1ns/10ps
`default_nettype none
module ssp_codec
(
  output logic rx_serial_in,
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic tx_bit_clock,
  output logic tx_frame_sync_in,
  input wire logic tx_serial_out_q,
  input wire logic tx_frame_sync_out_q
);
  initial {rx_serial_in, rx_bit_clock, rx_frame_sync} = 3'h0;
  initial {tx_bit_clock, tx_frame_sync_in} = 2'h0;
  // Sends w MSB first on receive; collects n transmit bits and sync outs.
  task automatic frame(input logic [15:0] w, input int n,
    output logic [15:0] got, output logic [15:0] syn);
    got = 16'h0000;
    syn = 16'h0000;
    #3;
    for (int i = n - 1; i >= 0; i--)
    begin
      rx_serial_in <= w[i];
      rx_frame_sync <= i == n - 1;
      tx_frame_sync_in <= i == n - 1;
      {rx_bit_clock, tx_bit_clock} <= 2'h3;
      #40;
      {rx_bit_clock, tx_bit_clock} <= 2'h0;
      got = {got[14:0], tx_serial_out_q};
      syn = {syn[14:0], tx_frame_sync_out_q};
      #40;
    end
    rx_serial_in <= ~rx_serial_in;
    {rx_frame_sync, tx_frame_sync_in} <= 2'h0;
  endtask
endmodule
`default_nettype wire

// >>> test/test_ssp_channel.sv
// Bench for one serial port channel with a codec model on its pins.
// Assumes the channel, checker and codec model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_ssp_channel;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic dma_rd = 1'b0;
  logic dma_wr = 1'b0;
  wire [15:0] reg_rdata_q;
  wire rx_serial_in, rx_bit_clock, rx_frame_sync, tx_bit_clock;
  wire tx_frame_sync_in, tx_serial_out_q, tx_serial_out_oe;
  wire tx_frame_sync_oe, rx_full_irq, tx_empty_irq;
  wire rx_overrun_irq, tx_underrun_irq, tx_frame_sync_out_q;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] sync_seen;
  always #4 clk = ~clk;
  ssp_channel dut_u (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .dma_rd, .dma_wr, .rx_serial_in, .rx_bit_clock,
    .rx_frame_sync, .tx_bit_clock, .tx_serial_out_q, .tx_serial_out_oe,
    .tx_frame_sync_in, .tx_frame_sync_out_q, .tx_frame_sync_oe,
    .rx_full_irq, .tx_empty_irq, .rx_overrun_irq, .tx_underrun_irq);
  ssp_codec cdc_u (.rx_serial_in, .rx_bit_clock, .rx_frame_sync,
    .tx_bit_clock, .tx_frame_sync_in, .tx_serial_out_q,
    .tx_frame_sync_out_q);
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string s, input logic [15:0] e,
    input logic [15:0] v);
    checks_done++;
    if (v !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask
  // Kinds: 0 write, 1 read, 2 dma read, 3 dma write.
  task automatic acc(input int k, input logic [3:0] a,
    input logic [15:0] d, output logic [15:0] q);
    reg_addr <= a;
    reg_wdata <= d;
    {dma_wr, dma_rd, reg_rd, reg_wr} <= 4'h1 << k;
    @(posedge clk);
    {dma_wr, dma_rd, reg_rd, reg_wr} <= 4'h0;
    @(posedge clk);
    q = reg_rdata_q;
  endtask
  task automatic link(input logic [15:0] w, input int n,
    output logic [15:0] q);
    cdc_u.frame(w, n, q, sync_seen);
    @(posedge clk);
  endtask
  task automatic t_regs;
    logic [15:0] q;
    for (int i = 0; i < 5; i++)
    begin
      acc(1, 4'(2 * i), 16'h0000, q);
      check("reset value", i == 3 ? 16'h0002 : 16'h0000, q);
    end
    acc(0, 4'h4, 16'hFFFF, q);
    acc(1, 4'h4, 16'h0000, q);
    check("ctrl", 16'h007F, q);
    acc(0, 4'h4, 16'h0000, q);
  endtask
  task automatic t_rx;
    logic [15:0] q;
    acc(0, 4'h4, 16'h0005, q);
    link(16'h00A5, 8, q);
    check("full irq", 16'h0001, 16'(rx_full_irq));
    link(16'h005A, 8, q);
    check("overrun", 16'h0001, 16'(rx_overrun_irq));
    acc(2, 4'h0, 16'h0000, q);
    check("rx word", 16'h005A, q);
    acc(0, 4'h4, 16'h0001, q);
    link(16'h0033, 8, q);
    check("full masked", 16'h0000, 16'(rx_full_irq));
    acc(0, 4'h4, 16'h0000, q);
    acc(1, 4'h6, 16'h0000, q);
    check("flags", 16'h0006, q);
    acc(0, 4'h6, 16'h0000, q);
    check("overrun", 16'h0000, 16'(rx_overrun_irq));
  endtask
  task automatic t_tx(input logic [15:0] c, input logic [15:0] d,
    input int n, input logic [15:0] e);
    logic [15:0] q;
    acc(0, 4'h4, c, q);
    acc(3, 4'h0, ~d, q);
    acc(0, 4'h2, d, q);
    check("empty irq", 16'h0000, 16'(tx_empty_irq));
    link(16'h0000, n, q);
    check("tx word", e, q);
    check("ext sync", 16'h0000, sync_seen);
    check("empty irq", 16'h0001, 16'(tx_empty_irq));
    link(16'h0000, n, q);
    check("underrun", 16'h0001, 16'(tx_underrun_irq));
    acc(1, 4'h6, 16'h0000, q);
    acc(0, 4'h6, 16'h0000, q);
    check("underrun", 16'h0000, 16'(tx_underrun_irq));
    acc(0, 4'h4, 16'h0000, q);
  endtask
  task automatic t_int;
    logic [15:0] q;
    acc(0, 4'h4, 16'h006B, q);
    acc(3, 4'h0, 16'h0096, q);
    link(16'h00C6, 8, q);
    check("int tx word", 16'h0096, q);
    check("int sync", 16'h0080, sync_seen);
    acc(2, 4'h0, 16'h0000, q);
    check("se rx word", 16'h00C6, q);
    link(16'h0081, 8, q);
    check("idle sync", 16'h0000, sync_seen);
    acc(1, 4'h6, 16'h0000, q);
    check("se flags", 16'h0003, q);
    acc(0, 4'h4, 16'h0000, q);
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rx();
    t_tx(16'h001A, 16'hC3A5, 16, 16'hC3A5);
    t_tx(16'h000A, 16'h1234, 8, 16'h0034);
    t_int();
    close_out();
  end
endmodule
bind ssp_channel ssp_channel_properties chk_u (.clk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .dma_rd, .dma_wr,
  .tx_serial_out_oe, .tx_frame_sync_oe, .rx_full_irq, .tx_empty_irq,
  .tx_underrun_irq);
`default_nettype wire
